// [testbench.sv]
// self-checking bench for the emulated transceiver register bank
`timescale 1ns/1ps
module testbench;
  localparam int P_HOLD = 20;
  logic        clk, rst, wr, rd, reload, rd_seen;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, v;
  logic        spd, fdx, loop, iso, colt, anc, txp, rxp;
  logic [1:0]  r;
  logic [20:0] e;
  logic [20:0] exp_q[$];
  int          err_count, checks_done, seed;
  logic [4:0]  rst_reg[3];
  logic [15:0] rst_bit[3];

  vpae_host_model u_host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
                          .o_reload(reload));
  vpae_core #(.P_SOFT_RST_CYCLES(P_HOLD)) u_dut (
    .i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .i_config_reload(reload), .o_rdata(rdata), .o_speed_100(spd), .o_full_duplex(fdx),
    .o_loopback(loop), .o_isolate(iso), .o_collision_test(colt), .o_an_complete(anc),
    .o_tx_pause_enable(txp), .o_rx_pause_enable(rxp));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : test_done

  task automatic chk_reg(input logic [4:0] a, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("unexpected reg %h expected %h seen %h", a, x, g);
    end
  endtask : chk_reg
  task automatic chk_out(input string n, input logic x, input logic g);
    checks_done++;
    if (g !== x) begin
      err_count++;
      $display("unexpected %s expected %b seen %b", n, x, g);
    end
  endtask : chk_out

  // read data appears in the cycle after the strobe and holds until the next read
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      e = exp_q.pop_front();
      chk_reg(e[20:16], e[15:0], rdata);
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic rd_exp(input logic [4:0] a, input logic [15:0] x);
    exp_q.push_back({a, x});
    u_host.rd(a);
  endtask : rd_exp
  task automatic outs(input logic s, input logic f);
    chk_out("speed_100", s, spd);
    chk_out("full_duplex", f, fdx);
  endtask : outs
  // speed and duplex bits left zero while negotiating
  task automatic neg(input logic [15:0] adv);
    u_host.wr(vpae_pkg::REG_ADV, adv);
    u_host.wr(vpae_pkg::REG_BCR, 16'h1200);
    cyc(8);
  endtask : neg
  function automatic logic [1:0] best_mode(input logic [3:0] ab);
    if (ab[3]) return 2'b11;
    if (ab[2]) return 2'b10;
    if (ab[1]) return 2'b01;
    if (ab[0]) return 2'b00;
    return 2'b10;
  endfunction : best_mode

  initial begin
    #200000;
    err_count++;
    test_done();
  end

  initial begin
    rst = 1'b1;
    seed = 32'h3a55382f;
    rst_reg = '{vpae_pkg::REG_RSTCTL, vpae_pkg::REG_PMT, vpae_pkg::REG_BCR};
    rst_bit = '{16'h0008, 16'h0400, 16'h8000};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    cyc(9);
    outs(1'b1, 1'b1);
    chk_out("an_complete", 1'b1, anc);
    rd_exp(vpae_pkg::REG_BCR, vpae_pkg::BCR_RESET);
    rd_exp(vpae_pkg::REG_BSR, 16'h782d);
    rd_exp(vpae_pkg::REG_ADV, vpae_pkg::ADV_RESET);
    rd_exp(vpae_pkg::REG_LPA, 16'h01e0);
    rd_exp(vpae_pkg::REG_EXP, 16'h0003);
    rd_exp(5'h1f, vpae_pkg::UNMAPPED);
    for (int i = 0; i < 24; i++) begin
      v = 16'($random(seed));
      v = (v & vpae_pkg::ADV_WMASK) | vpae_pkg::ADV_FIXED;
      // first pass: no common ability, partner pause still mirrored
      if (i == 0) v = 16'h0c01;
      neg(v);
      r = best_mode(v[8:5]);
      outs(r[1], r[0]);
      chk_out("tx_pause", r[0] & v[10], txp);
      chk_out("rx_pause", r[0] & v[10], rxp);
      rd_exp(vpae_pkg::REG_EXP, (v[8:5] != 4'h0) ? 16'h0003 : 16'h0002);
      rd_exp(vpae_pkg::REG_LPA, {4'h0, v[11:10], ((v[8:5] != 4'h0) ? 10'h1e0 : 10'h080)});
      rd_exp(vpae_pkg::REG_ADV, v);
    end
    neg(16'h01e1);
    u_host.wr(vpae_pkg::REG_ADV, 16'h0021);
    cyc(8);
    outs(1'b1, 1'b1);
    rd_exp(vpae_pkg::REG_LPA, 16'h01e0);
    u_host.wr(vpae_pkg::REG_BCR, 16'h1200);
    cyc(8);
    outs(1'b0, 1'b0);
    u_host.wr(vpae_pkg::REG_ADV, 16'h0041);
    u_host.wr(vpae_pkg::REG_RSTCTL, 16'h0400);
    cyc(8);
    outs(1'b0, 1'b1);
    rd_exp(vpae_pkg::REG_RSTCTL, 16'h0000);
    u_host.wr(vpae_pkg::REG_ADV, 16'h0081);
    u_host.reload();
    cyc(8);
    outs(1'b1, 1'b0);
    for (int i = 0; i < 4; i++) begin
      v = 16'h4480 | (i[1] ? 16'h2000 : 16'h0000) | (i[0] ? 16'h0100 : 16'h0000);
      u_host.wr(vpae_pkg::REG_BCR, v);
      cyc(3);
      outs(i[1], i[0]);
      chk_out("loopback", 1'b1, loop);
      chk_out("isolate", 1'b1, iso);
      chk_out("coltest", 1'b1, colt);
      chk_out("an_complete", 1'b0, anc);
      rd_exp(vpae_pkg::REG_BSR, 16'h780d);
    end
    u_host.wr(vpae_pkg::REG_MFC, 16'h0006);
    cyc(3);
    chk_out("tx_pause", 1'b1, txp);
    chk_out("rx_pause", 1'b1, rxp);
    rd_exp(vpae_pkg::REG_MFC, 16'h003e);
    rd_exp(vpae_pkg::REG_ADV, 16'h0081);
    u_host.wr(vpae_pkg::REG_BCR, 16'h1000);
    cyc(8);
    outs(1'b1, 1'b0);
    chk_out("rx_pause", 1'b0, rxp);
    u_host.wr(vpae_pkg::REG_MFC, 16'h0007);
    cyc(3);
    chk_out("rx_pause", 1'b1, rxp);
    u_host.wr(vpae_pkg::REG_MFC, 16'h0000);
    for (int j = 0; j < 3; j++) begin
      neg(16'h0021);
      u_host.wr(rst_reg[j], rst_bit[j]);
      rd_exp(rst_reg[j], (j == 2) ? vpae_pkg::BCR_RESET : rst_bit[j]);
      cyc(P_HOLD);
      rd_exp(rst_reg[j], (j == 2) ? vpae_pkg::BCR_RESET : 16'h0000);
      cyc(8);
      outs(1'b1, 1'b1);
      rd_exp(vpae_pkg::REG_ADV, vpae_pkg::ADV_RESET);
    end
    cyc(2);
    test_done();
  end
endmodule : testbench

// [vpae_core.sv]
// emulated transceiver register bank with emulated auto-negotiation
//
// Summary of operation
// - negotiate only while autoneg enable set
// - control bit 9 restarts negotiation
// - resets, digital reset, reload restart negotiation
// - steps: complete, page received, result
// - highest common mode by priority
// - advertisement resets with four abilities
// - later advertisement changes wait for rerun
// - partner advertises all four abilities when any is common
// - no next page, fault, T4
// - common ability sets partner-able, partner bits
// - none common: parallel detect 100 half
// - disabled: force speed, duplex from control
// - pause bits 10, 11 advertised
// - partner pause mirrors advertised pause
// - manual flow control register overrides, reports
// - manual register never alters advertised pause
// - reset control bit 3 soft reset, self-clears
// - control bit 15 soft reset, self-clears
// - power management bit 10 soft reset
// - speed, duplex, loopback, isolate, coltest, status outputs
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/1ps
module vpae_core #(
  parameter int P_SOFT_RST_CYCLES = vpae_pkg::SOFT_RST_CYCLES
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic [4:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_config_reload,
  output logic [15:0]      o_rdata,
  output logic             o_speed_100,
  output logic             o_full_duplex,
  output logic             o_loopback,
  output logic             o_isolate,
  output logic             o_collision_test,
  output logic             o_an_complete,
  output logic             o_tx_pause_enable,
  output logic             o_rx_pause_enable
);
  typedef struct packed {
    logic [15:0]          ctrl;
    logic [15:0]          adv;
    logic [15:0]          lp;
    logic                 an_done;
    logic                 page_rx;
    logic                 lp_able;
    logic                 res_100;
    logic                 res_fd;
    vpae_pkg::vpae_an_type an_state;
    logic                 rstctl_vphy;
    logic                 pmt_vphy;
    logic [2:0]           mfc;
    logic [15:0]          rdata;
    logic                 speed;
    logic                 fd;
    logic                 txfc;
    logic                 rxfc;
  } vpae_state_type;

  vpae_state_type st_q;
  vpae_state_type st_d;
  logic           timer_start;
  logic           timer_done;

  vpae_hold_timer #(
    .P_CYCLES (P_SOFT_RST_CYCLES)
  ) u_hold (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_start (timer_start),
    .o_done  (timer_done)
  );

  always_comb begin
    logic       wr_bcr;
    logic       wr_rst;
    logic       wr_pmt;
    logic       soft_rst;
    logic       restart;
    logic       man_fc;
    logic [3:0] common;
    wr_bcr   = i_wr && (i_addr == vpae_pkg::REG_BCR);
    wr_rst   = i_wr && (i_addr == vpae_pkg::REG_RSTCTL);
    wr_pmt   = i_wr && (i_addr == vpae_pkg::REG_PMT);
    common   = 4'h0;
    man_fc   = 1'b0;
    st_d     = st_q;
    timer_start = (wr_rst && i_wdata[vpae_pkg::RSTCTL_VPHY])
               || (wr_pmt && i_wdata[vpae_pkg::PMT_VPHY]);
    soft_rst = timer_start || (wr_bcr && i_wdata[vpae_pkg::BCR_RST]);
    restart  = soft_rst || (wr_rst && i_wdata[vpae_pkg::RSTCTL_DIG]) || i_config_reload;

    // register writes
    if (wr_bcr) begin
      st_d.ctrl = i_wdata & vpae_pkg::BCR_WMASK;
      if (i_wdata[vpae_pkg::BCR_RESTART]) begin
        restart = 1'b1;
      end
      if (i_wdata[vpae_pkg::BCR_AN_EN] && !st_q.ctrl[vpae_pkg::BCR_AN_EN]) begin
        restart = 1'b1;
      end
    end
    if (i_wr && (i_addr == vpae_pkg::REG_ADV)) begin
      st_d.adv = (i_wdata & vpae_pkg::ADV_WMASK) | vpae_pkg::ADV_FIXED;
    end
    if (i_wr && (i_addr == vpae_pkg::REG_MFC)) begin
      // only the manual register changes here, never the advertised pause
      st_d.mfc = i_wdata[vpae_pkg::MFC_RX:vpae_pkg::MFC_SEL];
    end

    // self-clearing soft reset bits: the start wins over the timeout
    if (timer_done) begin
      st_d.rstctl_vphy = 1'b0;
      st_d.pmt_vphy    = 1'b0;
    end
    if (wr_rst && i_wdata[vpae_pkg::RSTCTL_VPHY]) begin
      st_d.rstctl_vphy = 1'b1;
    end
    if (wr_pmt && i_wdata[vpae_pkg::PMT_VPHY]) begin
      st_d.pmt_vphy = 1'b1;
    end

    // soft reset completes at once, so control bit 15 never reads back set
    if (soft_rst) begin
      st_d.ctrl = vpae_pkg::BCR_RESET;
      st_d.adv  = vpae_pkg::ADV_RESET;
    end

    // emulated negotiation
    unique case (st_q.an_state)
      vpae_pkg::AN_IDLE: begin
      end
      vpae_pkg::AN_CLEAR: begin
        st_d.an_done = 1'b0;
        st_d.page_rx = 1'b0;
        st_d.lp_able = 1'b0;
        st_d.lp      = 16'h0000;
        st_d.an_state = st_q.ctrl[vpae_pkg::BCR_AN_EN] ? vpae_pkg::AN_STEP_DONE : vpae_pkg::AN_IDLE;
      end
      vpae_pkg::AN_STEP_DONE: begin
        st_d.an_done  = 1'b1;
        st_d.an_state = vpae_pkg::AN_STEP_PAGE;
      end
      vpae_pkg::AN_STEP_PAGE: begin
        st_d.page_rx  = 1'b1;
        st_d.an_state = vpae_pkg::AN_STEP_RESULT;
      end
      vpae_pkg::AN_STEP_RESULT: begin
        // advertisement sampled only here, so later edits wait for a rerun
        common = st_q.adv[vpae_pkg::ABIL_HI:vpae_pkg::ABIL_LO] & vpae_pkg::PARTNER_ALL;
        // partner pause copies ours; no next page, fault or T4 bits
        st_d.lp = 16'h0000;
        st_d.lp[vpae_pkg::ADV_SYM]  = st_q.adv[vpae_pkg::ADV_SYM];
        st_d.lp[vpae_pkg::ADV_ASYM] = st_q.adv[vpae_pkg::ADV_ASYM];
        if (common != 4'h0) begin
          st_d.lp_able = 1'b1;
          st_d.lp[vpae_pkg::ABIL_HI:vpae_pkg::ABIL_LO] = vpae_pkg::PARTNER_ALL;
          st_d.res_100 = common[3] || common[2];
          st_d.res_fd  = common[3] || (!common[2] && common[1]);
        end else begin
          st_d.lp_able = 1'b0;
          st_d.lp[vpae_pkg::ABIL_HI:vpae_pkg::ABIL_LO] = vpae_pkg::ABIL_PD;
          st_d.res_100 = 1'b1;
          st_d.res_fd  = 1'b0;
        end
        st_d.an_state = vpae_pkg::AN_IDLE;
      end
      default: begin
        st_d.an_state = vpae_pkg::AN_CLEAR;
      end
    endcase
    // dropping the enable abandons any run and withdraws the complete and page flags at once
    if (st_q.ctrl[vpae_pkg::BCR_AN_EN] && !st_d.ctrl[vpae_pkg::BCR_AN_EN]) begin
      st_d.an_done  = 1'b0;
      st_d.page_rx  = 1'b0;
      st_d.an_state = vpae_pkg::AN_CLEAR;
    end
    if (restart) begin
      st_d.an_state = vpae_pkg::AN_CLEAR;
    end

    // resolved operating mode: control bits count only when negotiation is off
    if (st_q.ctrl[vpae_pkg::BCR_AN_EN]) begin
      st_d.speed = st_q.res_100;
      st_d.fd    = st_q.res_fd;
    end else begin
      st_d.speed = st_q.ctrl[vpae_pkg::BCR_SPEED];
      st_d.fd    = st_q.ctrl[vpae_pkg::BCR_DUPLEX];
    end
    // partner mirrors our pause, so symmetric pause resolves both ways once full duplex is negotiated
    man_fc = !st_q.ctrl[vpae_pkg::BCR_AN_EN] || st_q.mfc[vpae_pkg::MFC_SEL];
    if (man_fc) begin
      st_d.txfc = st_q.mfc[vpae_pkg::MFC_TX];
      st_d.rxfc = st_q.mfc[vpae_pkg::MFC_RX];
    end else begin
      st_d.txfc = st_q.res_fd && st_q.an_done && st_q.lp[vpae_pkg::ADV_SYM];
      st_d.rxfc = st_q.res_fd && st_q.an_done && st_q.lp[vpae_pkg::ADV_SYM];
    end

    // read path, data valid in the cycle after the strobe
    if (i_rd) begin
      unique case (i_addr)
        vpae_pkg::REG_BCR:    st_d.rdata = st_q.ctrl;
        vpae_pkg::REG_BSR:    st_d.rdata = vpae_pkg::BSR_FIXED
                                         | (16'(st_q.an_done) << vpae_pkg::BSR_DONE);
        vpae_pkg::REG_ADV:    st_d.rdata = st_q.adv;
        vpae_pkg::REG_LPA:    st_d.rdata = st_q.lp;
        vpae_pkg::REG_EXP:    st_d.rdata = {14'h0000, st_q.page_rx, st_q.lp_able};
        vpae_pkg::REG_RSTCTL: st_d.rdata = 16'(st_q.rstctl_vphy) << vpae_pkg::RSTCTL_VPHY;
        vpae_pkg::REG_PMT:    st_d.rdata = 16'(st_q.pmt_vphy) << vpae_pkg::PMT_VPHY;
        vpae_pkg::REG_MFC:    st_d.rdata = {10'h000, st_q.rxfc, st_q.txfc, st_q.fd, st_q.mfc};
        default:              st_d.rdata = vpae_pkg::UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q          <= '0;
      st_q.ctrl     <= vpae_pkg::BCR_RESET;
      st_q.adv      <= vpae_pkg::ADV_RESET;
      st_q.an_state <= vpae_pkg::AN_CLEAR;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata           = st_q.rdata;
  assign o_speed_100       = st_q.speed;
  assign o_full_duplex     = st_q.fd;
  assign o_loopback        = st_q.ctrl[vpae_pkg::BCR_LOOP];
  assign o_isolate         = st_q.ctrl[vpae_pkg::BCR_ISO];
  assign o_collision_test  = st_q.ctrl[vpae_pkg::BCR_COLTEST];
  assign o_an_complete     = st_q.an_done;
  assign o_tx_pause_enable = st_q.txfc;
  assign o_rx_pause_enable = st_q.rxfc;

  a_an_needs_en: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(st_q.an_done) |-> st_q.ctrl[vpae_pkg::BCR_AN_EN])
    else $error("negotiation completed while disabled");

  a_restart_bit: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == vpae_pkg::REG_BCR && i_wdata[vpae_pkg::BCR_RESTART]
     && i_wdata[vpae_pkg::BCR_AN_EN] && !i_wdata[vpae_pkg::BCR_RST])
    ##1 (!i_wr && !i_config_reload) [*4] |-> ##[0:2] st_q.an_done)
    else $error("restart did not complete negotiation");

  a_steps_in_order: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(st_q.page_rx) |-> st_q.an_done && $past(st_q.an_done))
    else $error("page received before complete");

  a_top_mode_wins: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q.an_state == vpae_pkg::AN_STEP_RESULT && st_q.adv[vpae_pkg::ABIL_HI] && !i_wr && !i_config_reload)
    |=> st_q.res_100 && st_q.res_fd)
    else $error("100 full not chosen");

  a_partner_all: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q.an_state == vpae_pkg::AN_STEP_RESULT && st_q.adv[vpae_pkg::ABIL_HI:vpae_pkg::ABIL_LO] != 4'h0)
    |=> st_q.lp_able && st_q.lp[vpae_pkg::ABIL_HI:vpae_pkg::ABIL_LO] == vpae_pkg::PARTNER_ALL)
    else $error("partner abilities not shown");

  a_parallel_det: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q.an_state == vpae_pkg::AN_STEP_RESULT && st_q.adv[vpae_pkg::ABIL_HI:vpae_pkg::ABIL_LO] == 4'h0)
    |=> !st_q.lp_able && st_q.res_100 && !st_q.res_fd
        && st_q.lp[vpae_pkg::ABIL_HI:vpae_pkg::ABIL_LO] == vpae_pkg::ABIL_PD)
    else $error("parallel detect result wrong");

  a_forced_mode: assert property (@(posedge i_clk) disable iff (i_rst)
    !st_q.ctrl[vpae_pkg::BCR_AN_EN] |=> o_speed_100 == $past(st_q.ctrl[vpae_pkg::BCR_SPEED])
                                        && o_full_duplex == $past(st_q.ctrl[vpae_pkg::BCR_DUPLEX]))
    else $error("forced speed or duplex not applied");

  a_pause_mirror: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q.an_state == vpae_pkg::AN_STEP_RESULT
    |=> st_q.lp[vpae_pkg::ADV_ASYM:vpae_pkg::ADV_SYM] == $past(st_q.adv[vpae_pkg::ADV_ASYM:vpae_pkg::ADV_SYM]))
    else $error("partner pause does not mirror");

  a_rst_selfclear: assert property (@(posedge i_clk) disable iff (i_rst)
    (timer_done && !timer_start) |=> !st_q.rstctl_vphy && !st_q.pmt_vphy)
    else $error("soft reset bit did not clear");

  c_an_success: cover property (@(posedge i_clk) disable iff (i_rst) $rose(st_q.lp_able));
  c_parallel:   cover property (@(posedge i_clk) disable iff (i_rst)
    st_q.page_rx && !st_q.lp_able && st_q.an_state == vpae_pkg::AN_IDLE);
  c_soft_reset: cover property (@(posedge i_clk) disable iff (i_rst) timer_done);
  c_forced_mode: cover property (@(posedge i_clk) disable iff (i_rst)
    !st_q.ctrl[vpae_pkg::BCR_AN_EN] && st_q.speed && st_q.fd);
  c_manual_pause: cover property (@(posedge i_clk) disable iff (i_rst)
    st_q.ctrl[vpae_pkg::BCR_AN_EN] && st_q.mfc[vpae_pkg::MFC_SEL] && st_q.rxfc);

  a_flags_cleared: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q.an_state == vpae_pkg::AN_CLEAR |=> !st_q.an_done && !st_q.page_rx && !st_q.lp_able)
    else $error("flags not cleared on restart");

  a_rerun_starts: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q.an_state == vpae_pkg::AN_CLEAR && st_q.ctrl[vpae_pkg::BCR_AN_EN] && !i_wr && !i_config_reload)
    |=> st_q.an_state == vpae_pkg::AN_STEP_DONE)
    else $error("negotiation did not rerun after clear");

  a_done_first: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q.an_state == vpae_pkg::AN_STEP_DONE && !i_wr && !i_config_reload)
    |=> st_q.an_done && !st_q.page_rx && st_q.an_state == vpae_pkg::AN_STEP_PAGE)
    else $error("complete flag not set first");

  a_result_mode: assert property (@(posedge i_clk) disable iff (i_rst)
    st_q.ctrl[vpae_pkg::BCR_AN_EN] |=> o_speed_100 == $past(st_q.res_100)
                                       && o_full_duplex == $past(st_q.res_fd))
    else $error("negotiated mode not applied");

  a_partner_clean: assert property (@(posedge i_clk) disable iff (i_rst)
    (st_q.lp & ~vpae_pkg::ADV_WMASK) == 16'h0000)
    else $error("partner shows unsupported ability");

  a_ctrl_soft_reset: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == vpae_pkg::REG_BCR && i_wdata[vpae_pkg::BCR_RST])
    |=> st_q.ctrl == vpae_pkg::BCR_RESET && st_q.adv == vpae_pkg::ADV_RESET)
    else $error("control soft reset not applied");

  a_chip_reset_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == vpae_pkg::REG_RSTCTL && i_wdata[vpae_pkg::RSTCTL_VPHY])
    |=> st_q.rstctl_vphy && st_q.adv == vpae_pkg::ADV_RESET && st_q.an_state == vpae_pkg::AN_CLEAR)
    else $error("chip reset control soft reset not applied");

  a_power_reset_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == vpae_pkg::REG_PMT && i_wdata[vpae_pkg::PMT_VPHY])
    |=> st_q.pmt_vphy && st_q.adv == vpae_pkg::ADV_RESET && st_q.an_state == vpae_pkg::AN_CLEAR)
    else $error("power management soft reset not applied");

  a_hold_until_done: assert property (@(posedge i_clk) disable iff (i_rst)
    !timer_done |=> (!$past(st_q.rstctl_vphy) || st_q.rstctl_vphy) && (!$past(st_q.pmt_vphy) || st_q.pmt_vphy))
    else $error("soft reset bit cleared early");

  a_manual_pause: assert property (@(posedge i_clk) disable iff (i_rst)
    (!st_q.ctrl[vpae_pkg::BCR_AN_EN] || st_q.mfc[vpae_pkg::MFC_SEL])
    |=> o_tx_pause_enable == $past(st_q.mfc[vpae_pkg::MFC_TX])
        && o_rx_pause_enable == $past(st_q.mfc[vpae_pkg::MFC_RX]))
    else $error("manual flow control not applied");

  a_adv_pause_kept: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_wr && i_addr == vpae_pkg::REG_MFC) |=> $stable(st_q.adv[vpae_pkg::ADV_ASYM:vpae_pkg::ADV_SYM]))
    else $error("advertised pause changed by manual register");
endmodule : vpae_core

// [vpae_hold_timer.sv]
// one-shot timer that measures the soft reset hold time
`timescale 1ns/1ps
module vpae_hold_timer #(
  parameter int P_CYCLES = 12750
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_start,
  output logic      o_done
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        busy;
    logic        done;
  } vpae_tmr_type;
  vpae_tmr_type st_q;
  vpae_tmr_type st_d;
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (i_start) begin
      // a new start retriggers the full hold
      st_d.busy = 1'b1;
      st_d.cnt  = 16'(P_CYCLES - 1);
    end else if (st_q.busy) begin
      if (st_q.cnt == 16'h0000) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - 16'h0001;
      end
    end
  end
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign o_done = st_q.done;
endmodule : vpae_hold_timer

// [vpae_host_model.sv]
// host-side management master that drives the register port
`timescale 1ns/1ps
module vpae_host_model (
  input  wire logic   i_clk,
  output logic [4:0]  o_addr,
  output logic [15:0] o_wdata,
  output logic        o_wr,
  output logic        o_rd,
  output logic        o_reload
);
  initial begin
    o_addr   = 5'h00;
    o_wdata  = 16'h0000;
    o_wr     = 1'b0;
    o_rd     = 1'b0;
    o_reload = 1'b0;
  end
  // idle edge after each strobe, so a strobe is never lowered and raised in one step
  task automatic bus_cycle(input logic [4:0] a, input logic [15:0] d, input logic w);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= w;
    o_rd    <= ~w;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_rd    <= 1'b0;
    // released lines must not keep showing the last value
    o_addr  <= ~a;
    o_wdata <= ~d;
    @(posedge i_clk);
  endtask : bus_cycle
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus_cycle(a, d, 1'b1);
  endtask : wr
  task automatic rd(input logic [4:0] a);
    bus_cycle(a, 16'h0000, 1'b0);
  endtask : rd
  task automatic reload();
    o_reload <= 1'b1;
    @(posedge i_clk);
    o_reload <= 1'b0;
    @(posedge i_clk);
  endtask : reload
endmodule : vpae_host_model

// [vpae_pkg.sv]
// constants and types for the emulated transceiver register bank
package vpae_pkg;
  // register offsets
  localparam logic [4:0] REG_BCR    = 5'h00;
  localparam logic [4:0] REG_BSR    = 5'h01;
  localparam logic [4:0] REG_ADV    = 5'h04;
  localparam logic [4:0] REG_LPA    = 5'h05;
  localparam logic [4:0] REG_EXP    = 5'h06;
  localparam logic [4:0] REG_RSTCTL = 5'h10;
  localparam logic [4:0] REG_PMT    = 5'h11;
  localparam logic [4:0] REG_MFC    = 5'h12;
  // basic control fields
  localparam int BCR_RST     = 15;
  localparam int BCR_LOOP    = 14;
  localparam int BCR_SPEED   = 13;
  localparam int BCR_AN_EN   = 12;
  localparam int BCR_ISO     = 10;
  localparam int BCR_RESTART = 9;
  localparam int BCR_DUPLEX  = 8;
  localparam int BCR_COLTEST = 7;
  localparam logic [15:0] BCR_RESET = 16'h3100;
  localparam logic [15:0] BCR_WMASK = 16'h7580;
  // basic status
  localparam int BSR_DONE = 5;
  localparam logic [15:0] BSR_FIXED = 16'h780d;
  // advertisement / partner ability
  localparam int ABIL_LO  = 5;
  localparam int ABIL_HI  = 8;
  localparam int ADV_SYM  = 10;
  localparam int ADV_ASYM = 11;
  localparam logic [15:0] ADV_RESET = 16'h01e1;
  localparam logic [15:0] ADV_WMASK = 16'h0de0;
  localparam logic [15:0] ADV_FIXED = 16'h0001;
  localparam logic [3:0]  PARTNER_ALL = 4'hf;
  localparam logic [3:0]  ABIL_PD     = 4'h4;
  // expansion
  localparam int EXP_LPABLE = 0;
  localparam int EXP_PAGE   = 1;
  // chip reset / power management / manual flow control
  localparam int RSTCTL_VPHY = 3;
  localparam int RSTCTL_DIG  = 10;
  localparam int PMT_VPHY    = 10;
  localparam int MFC_SEL     = 0;
  localparam int MFC_TX      = 1;
  localparam int MFC_RX      = 2;
  localparam logic [15:0] UNMAPPED = 16'hffff;
  // soft reset hold time
  localparam int CLK_PERIOD_PS   = 8000;
  localparam int SOFT_RST_NS     = 102000;
  localparam int SOFT_RST_CYCLES = (SOFT_RST_NS * 1000) / CLK_PERIOD_PS;
  typedef enum logic [2:0] {
    AN_IDLE,
    AN_CLEAR,
    AN_STEP_DONE,
    AN_STEP_PAGE,
    AN_STEP_RESULT
  } vpae_an_type;
endpackage : vpae_pkg
